/* itf_decoder.sv */
/*
 * Input terminal function decoder: turns four ordinary and two
 * high-speed terminals into drive commands by per-terminal codes.
 * Assumes the rest of the drive consumes the command levels and that
 * configuration inputs are steady, on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "itf_regs.svh"
module itf_decoder
  import itf_pkg::*;
(
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_sys_rst,
  input  wire logic [`ITF_NUM_TERM-1:0] i_terminal_pins,
  input  wire itf_sel_vec_t             i_terminal_function_selectors,
  input  wire logic [`ITF_NUM_HS-1:0]   i_hs_pulse_mode,
  input  wire logic [`ITF_NUM_HS-1:0]   i_hs_pulse_is_encoder,
  input  wire logic                     i_freq_from_terminals,
  input  wire itf_ref_chan_t            i_combined_channel_selector,
  output logic                          o_run_fwd,
  output logic                          o_run_rev,
  output logic                          o_three_wire,
  output logic                          o_jog_fwd,
  output logic                          o_jog_rev,
  output logic                          o_coast_stop,
  output logic                          o_fault_reset,
  output logic                          o_pause,
  output logic                          o_ext_fault,
  output logic                          o_decel_stop,
  output logic                          o_freq_up,
  output logic                          o_freq_down,
  output logic                          o_freq_clear,
  output itf_ref_chan_t                 o_ref_channel,
  output logic [3:0]                    o_speed_index,
  output logic [`ITF_NUM_HS-1:0]        o_hs_pulse_freq,
  output logic [`ITF_NUM_HS-1:0]        o_hs_pulse_enc
);

  localparam int N = `ITF_NUM_TERM;

  // ****************************************************************
  // Decode helper
  // ****************************************************************

  // True when any enabled terminal carrying this code is active.
  // Duplicate codes are the configurer's fault; they simply OR here.
  function automatic logic func_on(
    input itf_code_t             code,
    input itf_sel_vec_t          sels,
    input logic [`ITF_NUM_TERM-1:0] act
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `ITF_NUM_TERM; i++)
      hit = hit | (act[i] && (sels[i] == code));
    return hit;
  endfunction

  // ****************************************************************
  // Terminal conditioning
  // ****************************************************************

  itf_term_if term ();

  assign term.raw = i_terminal_pins;

  // Synchroniser and debouncer for all six pins
  itf_debounce u_debounce (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .term      (term)
  );

  // Terminals that take part in function decoding
  logic [N-1:0] term_en;

  // High-speed terminals in pulse mode drop out of decoding
  always_comb
  begin
    term_en = term.clean;
    for (int h = 0; h < `ITF_NUM_HS; h++)
      if (i_hs_pulse_mode[h])
        term_en[`ITF_HS_FIRST + h] = 1'b0;
  end

  // ****************************************************************
  // Function decode
  // ****************************************************************

  logic act_fwd;
  logic act_rev;
  logic act_3w;
  logic act_jf;
  logic act_jr;
  logic act_coast;
  logic act_frst;
  logic act_pause;
  logic act_xflt;
  logic act_up;
  logic act_down;
  logic act_clear;
  logic act_ab;
  logic act_ca;
  logic act_cb;
  logic [3:0] act_ms;

  // Settings under a short name, so each decode fits on one line
  itf_sel_vec_t sel;
  assign sel = i_terminal_function_selectors;

  // Code zero is never looked up, so such a terminal does nothing
  always_comb
  begin
    act_fwd   = func_on(`ITF_FN_RUN_FWD,    sel, term_en);
    act_rev   = func_on(`ITF_FN_RUN_REV,    sel, term_en);
    act_3w    = func_on(`ITF_FN_THREE_WIRE, sel, term_en);
    act_jf    = func_on(`ITF_FN_JOG_FWD,    sel, term_en);
    act_jr    = func_on(`ITF_FN_JOG_REV,    sel, term_en);
    act_coast = func_on(`ITF_FN_COAST,      sel, term_en);
    act_frst  = func_on(`ITF_FN_FAULT_RST,  sel, term_en);
    act_pause = func_on(`ITF_FN_PAUSE,      sel, term_en);
    act_xflt  = func_on(`ITF_FN_EXT_FAULT,  sel, term_en);
    act_up    = func_on(`ITF_FN_FREQ_UP,    sel, term_en);
    act_down  = func_on(`ITF_FN_FREQ_DOWN,  sel, term_en);
    act_clear = func_on(`ITF_FN_FREQ_CLEAR, sel, term_en);
    act_ab    = func_on(`ITF_FN_SW_AB,      sel, term_en);
    act_ca    = func_on(`ITF_FN_SW_COMB_A,  sel, term_en);
    act_cb    = func_on(`ITF_FN_SW_COMB_B,  sel, term_en);
    act_ms[0] = func_on(`ITF_FN_MS1,        sel, term_en);
    act_ms[1] = func_on(`ITF_FN_MS2,        sel, term_en);
    act_ms[2] = func_on(`ITF_FN_MS3,        sel, term_en);
    act_ms[3] = func_on(`ITF_FN_MS4,        sel, term_en);
  end

  // ****************************************************************
  // Command registers
  // ****************************************************************

  logic [10:0]   lvl_reg;
  logic [10:0]   lvl_next;
  logic          frst_prev_reg;
  logic          frst_prev_next;
  logic          frst_pulse_reg;
  logic          frst_pulse_next;
  logic          xflt_reg;
  logic          xflt_next;
  itf_ref_chan_t chan_reg;
  itf_ref_chan_t chan_next;
  logic [3:0]    idx_reg;
  logic [3:0]    idx_next;
  logic [`ITF_NUM_HS-1:0] pf_reg;
  logic [`ITF_NUM_HS-1:0] pf_next;
  logic [`ITF_NUM_HS-1:0] pe_reg;
  logic [`ITF_NUM_HS-1:0] pe_next;

  // Next command state
  always_comb
  begin
    lvl_next = {act_fwd, act_rev, act_3w, act_jf, act_jr,
                act_coast, act_pause,
                act_up & i_freq_from_terminals,
                act_down & i_freq_from_terminals,
                act_clear,
                act_pause | xflt_reg};
    // Fault reset fires once per rising edge, like one key press
    frst_prev_next  = act_frst;
    frst_pulse_next = act_frst & ~frst_prev_reg;
    // Alarm latches; a new fault wins over a reset in the same cycle
    if (act_xflt)
      xflt_next = 1'b1;
    else if (frst_pulse_reg)
      xflt_next = 1'b0;
    else
      xflt_next = xflt_reg;
    // Channel switching; the A/B swap takes priority
    chan_next = i_combined_channel_selector;
    if (act_ab)
    begin
      if (i_combined_channel_selector == ITF_CH_A)
        chan_next = ITF_CH_B;
      else if (i_combined_channel_selector == ITF_CH_B)
        chan_next = ITF_CH_A;
    end
    else if (act_ca)
    begin
      if (i_combined_channel_selector == ITF_CH_COMB)
        chan_next = ITF_CH_A;
      else if (i_combined_channel_selector == ITF_CH_A)
        chan_next = ITF_CH_COMB;
    end
    else if (act_cb)
    begin
      if (i_combined_channel_selector == ITF_CH_COMB)
        chan_next = ITF_CH_B;
      else if (i_combined_channel_selector == ITF_CH_B)
        chan_next = ITF_CH_COMB;
    end
    // Bit 3 is speed terminal 4, bit 0 is speed terminal 1
    idx_next = act_ms;
    // Pulse-mode pins pass straight through, synchronised only
    pf_next = '0;
    pe_next = '0;
    for (int h = 0; h < `ITF_NUM_HS; h++)
    begin
      if (i_hs_pulse_mode[h] && i_hs_pulse_is_encoder[h])
        pe_next[h] = term.synced[`ITF_HS_FIRST + h];
      else if (i_hs_pulse_mode[h])
        pf_next[h] = term.synced[`ITF_HS_FIRST + h];
    end
  end

  // Register all commands
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      lvl_reg        <= '0;
      frst_prev_reg  <= `ITF_RST_LEVEL;
      frst_pulse_reg <= `ITF_RST_LEVEL;
      xflt_reg       <= `ITF_RST_LEVEL;
      chan_reg       <= ITF_CH_A;
      idx_reg        <= `ITF_RST_INDEX;
      pf_reg         <= '0;
      pe_reg         <= '0;
    end
    else
    begin
      lvl_reg        <= lvl_next;
      frst_prev_reg  <= frst_prev_next;
      frst_pulse_reg <= frst_pulse_next;
      xflt_reg       <= xflt_next;
      chan_reg       <= chan_next;
      idx_reg        <= idx_next;
      pf_reg         <= pf_next;
      pe_reg         <= pe_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Pause state is only held here; the drive resumes from it
  assign o_run_fwd       = lvl_reg[10];
  assign o_run_rev       = lvl_reg[9];
  assign o_three_wire    = lvl_reg[8];
  assign o_jog_fwd       = lvl_reg[7];
  assign o_jog_rev       = lvl_reg[6];
  assign o_coast_stop    = lvl_reg[5];
  assign o_pause         = lvl_reg[4];
  assign o_freq_up       = lvl_reg[3];
  assign o_freq_down     = lvl_reg[2];
  assign o_freq_clear    = lvl_reg[1];
  assign o_decel_stop    = lvl_reg[0];
  assign o_fault_reset   = frst_pulse_reg;
  assign o_ext_fault     = xflt_reg;
  assign o_ref_channel   = chan_reg;
  assign o_speed_index   = idx_reg;
  assign o_hs_pulse_freq = pf_reg;
  assign o_hs_pulse_enc  = pe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_code_zero_idle:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_terminal_function_selectors == '0) ##1
    (i_terminal_function_selectors == '0) |->
    !o_run_fwd && !o_coast_stop && !o_pause && o_speed_index == 4'h0)
    else $error("Code zero terminal caused an action");

  a_run_fwd_follow:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    act_fwd |=> o_run_fwd)
    else $error("Forward run not commanded");

  a_coast_next_cycle:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(act_coast) |=> o_coast_stop)
    else $error("Coast stop late");

  a_fault_reset_once:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    o_fault_reset |=> !o_fault_reset ##0 $past(act_frst))
    else $error("Fault reset is not a single pulse");

  a_ext_fault_latch:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    act_xflt |=> o_ext_fault ##1 o_decel_stop)
    else $error("External fault not latched or no stop");

  a_up_needs_terminal:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_freq_from_terminals |=> !o_freq_up && !o_freq_down)
    else $error("Frequency step without terminal reference");

  a_ab_swap_b:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    act_ab && i_combined_channel_selector == ITF_CH_A
    |=> o_ref_channel == ITF_CH_B)
    else $error("A/B swap did not select B");

  a_ms4_top_bit:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    act_ms == 4'h8 |=> o_speed_index == 4'h8)
    else $error("Speed terminal 4 not most significant");

  a_pulse_mode_excl:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    i_hs_pulse_mode[0] && !i_hs_pulse_is_encoder[0] |=> !o_hs_pulse_enc[0]
    && o_hs_pulse_freq[0] == $past(term.synced[`ITF_HS_FIRST]))
    else $error("Pulse-mode terminal not routed to its output");

endmodule

`default_nettype wire

/* itf_regs.svh */
/*
 * Constants for the input terminal function decoder: function codes,
 * terminal counts, debounce timing and reset values.
 * Assumes a 25 MHz system clock; the debounce count is derived from it.
 */
`ifndef ITF_REGS_SVH
`define ITF_REGS_SVH

// ****************************************************************
// Terminal layout
// ****************************************************************
`define ITF_NUM_TERM       6
`define ITF_NUM_HS         2
`define ITF_HS_FIRST       4
`define ITF_CODE_W         5

// ****************************************************************
// Function codes
// ****************************************************************
`define ITF_FN_NONE        5'h00
`define ITF_FN_RUN_FWD     5'h01
`define ITF_FN_RUN_REV     5'h02
`define ITF_FN_THREE_WIRE  5'h03
`define ITF_FN_JOG_FWD     5'h04
`define ITF_FN_JOG_REV     5'h05
`define ITF_FN_COAST       5'h06
`define ITF_FN_FAULT_RST   5'h07
`define ITF_FN_PAUSE       5'h08
`define ITF_FN_EXT_FAULT   5'h09
`define ITF_FN_FREQ_UP     5'h0a
`define ITF_FN_FREQ_DOWN   5'h0b
`define ITF_FN_FREQ_CLEAR  5'h0c
`define ITF_FN_SW_AB       5'h0d
`define ITF_FN_SW_COMB_A   5'h0e
`define ITF_FN_SW_COMB_B   5'h0f
`define ITF_FN_MS1         5'h10
`define ITF_FN_MS2         5'h11
`define ITF_FN_MS3         5'h12
`define ITF_FN_MS4         5'h13

// ****************************************************************
// Timing and reset values
// ****************************************************************
`define ITF_CLK_PERIOD_NS  40
`define ITF_DEB_TIME_NS    2000
`define ITF_DEB_CYCLES     ((`ITF_DEB_TIME_NS + `ITF_CLK_PERIOD_NS - 1) / `ITF_CLK_PERIOD_NS)
`define ITF_DEB_CNT_W      6
`define ITF_RST_LEVEL      1'b0
`define ITF_RST_INDEX      4'h0

`endif

/* itf_pkg.sv */
/*
 * Types shared by the input terminal function decoder files.
 * Assumes itf_regs.svh is on the include path.
 */
`include "itf_regs.svh"

package itf_pkg;

  // One terminal's function setting
  typedef logic [`ITF_CODE_W-1:0] itf_code_t;

  // All six terminal settings, terminal 0 in the low slot
  typedef itf_code_t [`ITF_NUM_TERM-1:0] itf_sel_vec_t;

  // Frequency reference channel, one-hot
  typedef enum logic [2:0] {
    ITF_CH_A    = 3'h1,
    ITF_CH_B    = 3'h2,
    ITF_CH_COMB = 3'h4
  } itf_ref_chan_t;

endpackage

/* itf_term_if.sv */
/*
 * Carries terminal levels between the debouncer and the decoder.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "itf_regs.svh"

interface itf_term_if;
  logic [`ITF_NUM_TERM-1:0] raw;    // Pin levels, unsynchronised
  logic [`ITF_NUM_TERM-1:0] synced; // After two flops, not filtered
  logic [`ITF_NUM_TERM-1:0] clean;  // Debounced levels

  modport deb (input raw, output synced, output clean);
  modport dec (output raw, input synced, input clean);
endinterface

`default_nettype wire

/* itf_debounce.sv */
/*
 * Two-flop synchroniser and stability filter for every terminal pin.
 * Assumes pins are asynchronous to i_sys_clk; reset is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "itf_regs.svh"

module itf_debounce
  import itf_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  itf_term_if.deb   term
);

  localparam int N = `ITF_NUM_TERM;
  localparam logic [`ITF_DEB_CNT_W-1:0] DEB_LAST =
    `ITF_DEB_CNT_W'(`ITF_DEB_CYCLES - 1);

  logic [N-1:0]                meta_reg;
  logic [N-1:0]                sync_reg;
  logic [N-1:0]                clean_reg;
  logic [N-1:0]                clean_next;
  logic [`ITF_DEB_CNT_W-1:0]   cnt_reg  [N];
  logic [`ITF_DEB_CNT_W-1:0]   cnt_next [N];

  // ****************************************************************
  // Filter: a level change is taken only after it held for the
  // whole debounce time; a bounce restarts the count
  // ****************************************************************
  always_comb
  begin
    clean_next = clean_reg;
    for (int i = 0; i < N; i++)
    begin
      cnt_next[i] = '0;
      if (sync_reg[i] != clean_reg[i])
      begin
        if (cnt_reg[i] == DEB_LAST)
          clean_next[i] = sync_reg[i];
        else
          cnt_next[i] = cnt_reg[i] + 1'b1;
      end
    end
  end

  // Registers; the first flop feeds only the second
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      meta_reg  <= '0;
      sync_reg  <= '0;
      clean_reg <= '0;
      for (int i = 0; i < N; i++)
        cnt_reg[i] <= '0;
    end
    else
    begin
      meta_reg  <= term.raw;
      sync_reg  <= meta_reg;
      clean_reg <= clean_next;
      for (int i = 0; i < N; i++)
        cnt_reg[i] <= cnt_next[i];
    end
  end

  assign term.synced = sync_reg;
  assign term.clean  = clean_reg;

  a_clean_held_stable:
  assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $changed(clean_reg[0]) |-> $past(cnt_reg[0]) == DEB_LAST)
    else $error("Terminal level taken before debounce time");

endmodule

`default_nettype wire

/* itf_switch_model.sv */
/*
 * Model of the external switches wired to the six terminal pins.
 * Assumes the bench calls its tasks and that pins idle low.
 */
`timescale 1ns/1ps
`default_nettype none

module itf_switch_model
(
  input  wire logic  i_sys_clk,
  output logic [5:0] o_pins
);
  // Open contacts read low through the input pull-downs
  initial o_pins = 6'h00;

  // Contacts chatter before they settle, so changed pins flip back first
  task automatic put(input logic [5:0] v, input int bounces);
    logic [5:0] old;
    old = o_pins;
    for (int k = 0; k < bounces; k++)
    begin
      @(posedge i_sys_clk);
      o_pins <= v;
      repeat (3) @(posedge i_sys_clk);
      o_pins <= old;
    end
    @(posedge i_sys_clk);
    o_pins <= v;
  endtask

  // Brief closure, as from a knock on a relay, then the old levels
  task automatic blip(input logic [5:0] v, input int len);
    logic [5:0] old;
    old = o_pins;
    @(posedge i_sys_clk);
    o_pins <= v;
    repeat (len) @(posedge i_sys_clk);
    o_pins <= old;
  endtask
endmodule

`default_nettype wire

/* input_terminal_function_decoder_test.sv */
/*
 * Self-checking bench for the terminal function decoder.
 * Assumes the switch model drives the pins; all else is driven here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "itf_regs.svh"

module input_terminal_function_decoder_test
  import itf_pkg::*;
;
  logic          sys_clk;
  logic          sys_rst;
  logic [5:0]    pins;
  itf_sel_vec_t  sels;
  logic [1:0]    pulse_mode;
  logic [1:0]    is_enc;
  logic          freq_term;
  itf_ref_chan_t base_ch;
  logic          run_fwd, run_rev, three_wire, jog_fwd, jog_rev, coast;
  logic          fault_rst, pause, ext_fault, decel, up, down, clr;
  itf_ref_chan_t ref_ch;
  logic [3:0]    speed;
  logic [1:0]    hs_freq;
  logic [1:0]    hs_enc;
  int            miscompares = 0;
  int            check_count = 0;

  itf_switch_model sw (.i_sys_clk(sys_clk), .o_pins(pins));

  itf_decoder dut (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_terminal_pins(pins),
    .i_terminal_function_selectors(sels), .i_hs_pulse_mode(pulse_mode),
    .i_hs_pulse_is_encoder(is_enc), .i_freq_from_terminals(freq_term),
    .i_combined_channel_selector(base_ch), .o_run_fwd(run_fwd),
    .o_run_rev(run_rev), .o_three_wire(three_wire), .o_jog_fwd(jog_fwd),
    .o_jog_rev(jog_rev), .o_coast_stop(coast), .o_fault_reset(fault_rst),
    .o_pause(pause), .o_ext_fault(ext_fault), .o_decel_stop(decel),
    .o_freq_up(up), .o_freq_down(down), .o_freq_clear(clr),
    .o_ref_channel(ref_ch), .o_speed_index(speed),
    .o_hs_pulse_freq(hs_freq), .o_hs_pulse_enc(hs_enc));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Longer than sync plus debounce plus decode, so a change has landed
  task automatic settle();
    repeat (60) @(posedge sys_clk);
    #1;
  endtask

  // Codes are set while pins are low; one code per terminal at most
  task automatic set_codes(input itf_sel_vec_t sv);
    @(posedge sys_clk);
    sels <= sv;
  endtask

  function automatic logic [10:0] levels();
    return {run_fwd, run_rev, three_wire, jog_fwd, jog_rev, coast, pause,
            up, down, clr, decel};
  endfunction

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Each level code on a rotating terminal, high-speed ones included
  task automatic test_codes();
    itf_code_t    codes [11];
    itf_sel_vec_t sv;
    logic [10:0]  exp;
    int           t;
    codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
              5'h0a, 5'h0b, 5'h0c};
    for (int i = 0; i < 11; i++)
    begin
      t = i % 6;
      exp = (i == 0) ? 11'h000 : (11'h400 >> (i - 1));
      if (codes[i] == 5'h08)
        exp = exp | 11'h001;
      sv = '0;
      sv[t] = codes[i];
      set_codes(sv);
      sw.put(6'h01 << t, 2);
      settle();
      check(levels(), exp);
      sw.put(6'h00, 1);
      settle();
      check(levels(), 11'h000);
    end
    // Up is ignored when the frequency is not set from terminals
    sv = '0;
    sv[1] = 5'h0a;
    set_codes(sv);
    freq_term <= 1'b0;
    sw.put(6'h02, 0);
    settle();
    check(up, 1'b0);
    sw.put(6'h00, 0);
    settle();
  endtask

  // Latched external fault, cleared by a one-cycle reset pulse
  task automatic test_fault();
    itf_sel_vec_t sv;
    int           n;
    sv = '0;
    sv[1] = 5'h09;
    sv[2] = 5'h07;
    set_codes(sv);
    sw.put(6'h02, 1);
    settle();
    check({ext_fault, decel}, 2'h3);
    sw.put(6'h00, 1);
    settle();
    check(ext_fault, 1'b1);
    sw.put(6'h04, 0);
    n = 0;
    while (fault_rst !== 1'b1 && n < 80)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(fault_rst, 1'b1);
    @(posedge sys_clk);
    #1;
    check(fault_rst, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    check({ext_fault, decel}, 2'h0);
    sw.put(6'h00, 0);
    settle();
    check(fault_rst, 1'b0);
  endtask

  // A closure shorter than the debounce time must not reach a command
  // One cycle short of the debounce time is dropped, the full time taken
  task automatic test_glitch();
    itf_sel_vec_t sv;
    logic         seen;
    sv = '0;
    sv[3] = 5'h01;
    set_codes(sv);
    for (int len = `ITF_DEB_CYCLES - 1; len <= `ITF_DEB_CYCLES; len++)
    begin
      seen = 1'b0;
      sw.blip(6'h08, len);
      // Watch every cycle, as a passed closure shows only briefly
      repeat (60)
      begin
        @(posedge sys_clk);
        #1;
        seen = seen | run_fwd;
      end
      check(seen, len == `ITF_DEB_CYCLES);
      settle();
      check(run_fwd, 1'b0);
    end
  endtask

  // Four speed terminals form the index, terminal with code 16 lowest
  task automatic test_speed();
    logic [3:0] pats [5];
    pats = '{4'h1, 4'h2, 4'h4, 4'h8, 4'ha};
    set_codes({5'h00, 5'h00, 5'h13, 5'h12, 5'h11, 5'h10});
    foreach (pats[i])
    begin
      sw.put({2'h0, pats[i]}, 1);
      settle();
      check(speed, pats[i]);
    end
    sw.put(6'h00, 0);
    settle();
    check(speed, 4'h0);
  endtask

  // Channel switch codes against every base they act on
  task automatic test_channel();
    itf_ref_chan_t bases [6];
    itf_ref_chan_t exps [6];
    int            terms [6];
    bases = '{ITF_CH_A, ITF_CH_B, ITF_CH_COMB, ITF_CH_A, ITF_CH_COMB,
              ITF_CH_B};
    exps = '{ITF_CH_B, ITF_CH_A, ITF_CH_A, ITF_CH_COMB, ITF_CH_B,
             ITF_CH_COMB};
    terms = '{0, 0, 1, 1, 2, 2};
    set_codes({5'h00, 5'h00, 5'h00, 5'h0f, 5'h0e, 5'h0d});
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      base_ch <= bases[i];
      repeat (3) @(posedge sys_clk);
      #1;
      check(ref_ch, bases[i]);
      sw.put(6'h01 << terms[i], 1);
      settle();
      check(ref_ch, exps[i]);
      sw.put(6'h00, 0);
      settle();
    end
  endtask

  // High-speed pins in pulse mode feed the pulse outputs, not commands
  task automatic test_pulse();
    @(posedge sys_clk);
    pulse_mode <= 2'h3;
    is_enc <= 2'h2;
    set_codes({5'h02, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00});
    sw.put(6'h30, 0);
    repeat (8) @(posedge sys_clk);
    #1;
    check({hs_enc, hs_freq}, 4'h9);
    settle();
    check({run_fwd, run_rev}, 2'h0);
    sw.put(6'h00, 0);
    settle();
    check({hs_enc, hs_freq}, 4'h0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    sys_rst = 1'b1;
    sels = '0;
    pulse_mode = 2'h0;
    is_enc = 2'h0;
    freq_term = 1'b1;
    base_ch = ITF_CH_A;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({levels(), fault_rst, ext_fault}, 13'h0000);
    check(ref_ch, ITF_CH_A);
    test_codes();
    test_fault();
    test_glitch();
    test_speed();
    test_channel();
    test_pulse();
    conclude();
  end

  // Whole run needs about 3500 cycles; over five times that means a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule

`default_nettype wire
